// >>> rtl/icd_pkg.sv
package icd_pkg;
   localparam int          NUM_IRQ      = 8;
   localparam int          RESP_DEPTH   = 4;
   // APB map
   localparam logic [7:0]  ADDR_CMD     = 8'h00;
   localparam logic [7:0]  ADDR_DATA    = 8'h04;
   localparam logic [7:0]  ADDR_STATUS  = 8'h08;
   localparam logic [7:0]  ADDR_IRR     = 8'h0c;
   localparam logic [7:0]  ADDR_ISR     = 8'h10;
   localparam logic [7:0]  ADDR_IMR     = 8'h14;
   localparam logic [7:0]  ADDR_ACR     = 8'h18;
   localparam logic [7:0]  ADDR_MODE    = 8'h1c;
   localparam logic [7:0]  ADDR_RESP    = 8'h20;
   // Reset values
   localparam logic [7:0]  MASK_RESET   = 8'hff;
   localparam logic [7:0]  ZERO8        = 8'h00;
   // Mode bit positions
   localparam int          MODE_ARM     = 7;
   localparam int          MODE_IRQ_POL = 4;
   // Arm control field codes
   localparam logic [1:0]  ARM_KEEP     = 2'h0;
   localparam logic [1:0]  ARM_SET      = 2'h1;
   localparam logic [1:0]  ARM_CLR      = 2'h2;
   // Read preselect codes
   localparam logic [1:0]  RSEL_IRR     = 2'h0;
   localparam logic [1:0]  RSEL_ISR     = 2'h1;
   localparam logic [1:0]  RSEL_IMR     = 2'h2;
   localparam logic [1:0]  RSEL_ACR     = 2'h3;

   typedef enum logic [4:0] {
      ICD_OP_RESET     = 5'b00000,
      ICD_OP_CLR_ALL_M = 5'b00010,
      ICD_OP_CLR_BIT_M = 5'b00011,
      ICD_OP_CLR_MASK  = 5'b00100,
      ICD_OP_CLR_MBIT  = 5'b00101,
      ICD_OP_SET_MASK  = 5'b00110,
      ICD_OP_SET_MBIT  = 5'b00111,
      ICD_OP_CLR_REQ   = 5'b01000,
      ICD_OP_CLR_RBIT  = 5'b01001,
      ICD_OP_SET_REQ   = 5'b01010,
      ICD_OP_SET_RBIT  = 5'b01011,
      ICD_OP_CLR_ISALL = 5'b01110,
      ICD_OP_CLR_ISBIT = 5'b01111
   } icd_op_t;

   typedef enum logic [1:0] {
      ICD_TGT_NONE = 2'b00,
      ICD_TGT_MASK = 2'b01,
      ICD_TGT_ACLR = 2'b10,
      ICD_TGT_RESP = 2'b11
   } icd_tgt_t;
endpackage

// >>> rtl/icd_resp_mem.sv
`timescale 1ns/1ps
module icd_resp_mem
   import icd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       sel_level,
   input  wire logic [2:0] level,
   input  wire logic [1:0] count_in,
   input  wire logic       wr_byte,
   input  wire logic [7:0] wr_data,
   input  wire logic       ack,
   input  wire logic [2:0] ack_level,
   output logic      [7:0] rd_data,
   output logic            rd_last
);
   logic [7:0] mem [NUM_IRQ][RESP_DEPTH];
   logic [1:0] count [NUM_IRQ];
   logic [1:0] wr_ptr;
   logic [1:0] rd_ptr;

   // Memory and counts have no reset: software reset must leave them intact
   always_ff @(posedge clk) begin
      if (sel_level) begin
         count[level] <= count_in;
      end
      if (wr_byte) begin
         mem[level][wr_ptr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || sel_level) begin
         wr_ptr <= 2'h0;
      end else if (wr_byte && wr_ptr != 2'h3) begin
         wr_ptr <= wr_ptr + 2'h1;
      end
   end

   // Read order follows load order; count, not writes, ends the sequence
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_ptr  <= 2'h0;
         rd_data <= ZERO8;
         rd_last <= 1'b0;
      end else if (ack) begin
         rd_data <= mem[ack_level][rd_ptr];
         rd_last <= (rd_ptr == count[ack_level]);
         rd_ptr  <= (rd_ptr == count[ack_level]) ? 2'h0 : rd_ptr + 2'h1;
      end
   end
endmodule

// >>> rtl/icd_decoder.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Reset command sets mask all ones; clears in-service, request, auto-clear, mode.
// - Software reset leaves response memory and byte counts untouched.
// - 00010xxx clears all mask and request bits; group output drops unless a same-cycle edge sets a request.
// - 00011bbb clears indexed mask bit and request bit only.
// - 00100xxx clears every mask bit.
// - 00101bbb clears only the indexed mask bit.
// - 00110xxx sets every mask bit, blocking all requests.
// - 00111bbb sets only the indexed mask bit.
// - 01000xxx clears all request bits; only new edges set them.
// - 01001bbb clears only the indexed request bit.
// - 01010xxx sets all eight request bits.
// - 01011bbb sets indexed request bit like a hardware request.
// - 0110xxxx clears highest-priority set in-service bit.
// - 01110xxx clears every in-service bit.
// - 01111bbb clears indexed in-service bit; no change if clear.
// - 100mmmmm copies command bits 4..0 into mode bits 4..0.
// - 1010ssnn loads bits 3,2 into read preselect mode bits 6,5.
// - Arm field: 00 keep, 01 set, 10 clear, 11 keep.
// - 1011xxxx targets data writes at mask register until next command.
// - 1100xxxx targets data writes at auto-clear register until next command.
// - 111ccLLL stores byte count for level LLL and targets it.
// - Byte count sets acknowledge read-out length; bytes leave in load order.
// - Disarmed: requests latch, group output stays low, enable out low.
module icd_decoder
   import icd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  irq_inputs,
   input  wire logic        irq_ack_in,
   output logic             group_irq_out,
   output logic             enable_out,
   output logic      [7:0]  resp_byte,
   output logic             resp_last
);
   import icd_pkg::*;

   logic [7:0] mask_register;
   logic [7:0] request_register;
   logic [7:0] in_service_register;
   logic [7:0] auto_clear_register;
   logic [7:0] mode;
   icd_tgt_t   target;
   logic [2:0] resp_level;
   logic [7:0] irq_prev;
   logic [7:0] irq_edge;
   logic [7:0] is_low_mask;
   logic [7:0] pending;
   logic [2:0] ack_sel;
   logic       ack_valid;
   logic       ack_d;
   logic       ack_rise;
   logic       in_resp;
   logic [2:0] resp_sel;
   logic [7:0] read_sel_value;
   logic [31:0] next_prdata;
   logic       mem_last;
   logic [7:0] mem_byte;
   logic [7:0] isr_cleared;

   wire        access   = psel && penable;
   wire        cmd_wr   = access && pwrite && paddr == ADDR_CMD;
   wire        data_wr  = access && pwrite && paddr == ADDR_DATA;
   wire [7:0]  cmd      = pwdata[7:0];
   wire [2:0]  bit_idx  = cmd[2:0];
   wire [7:0]  bit_oh   = 8'h01 << bit_idx;
   wire        soft_rst = cmd_wr && cmd == ZERO8;
   wire        op_excl  = cmd_wr && cmd[7:4] == 4'h6;
   wire        op_mode  = cmd_wr && cmd[7:5] == 3'b100;
   wire        op_ctl   = cmd_wr && cmd[7:4] == 4'ha;
   wire        op_resp  = cmd_wr && cmd[7:5] == 3'b111;
   wire        is_op    = cmd_wr && !cmd[7];
   wire        armed    = mode[MODE_ARM];
   // Only the first byte of a response claims the request
   wire        mem_ack  = ack_rise && (in_resp || ack_valid);
   wire        ack_take = ack_rise && !in_resp && ack_valid;
   wire [7:0]  ack_bit  = 8'h01 << ack_sel;
   wire [7:0]  ack_clr  = ack_take ? ack_bit : ZERO8;
   wire [7:0]  req_base = request_register & ~ack_clr;
   wire [7:0]  isr_set  = (ack_take && !auto_clear_register[ack_sel]) ? ack_bit : ZERO8;

   // Hardware edges in the active sense selected by mode bit 4
   always_comb begin
      irq_edge = mode[MODE_IRQ_POL] ? (irq_inputs & ~irq_prev)
                                    : (~irq_inputs & irq_prev);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_prev <= ZERO8;
      end else begin
         irq_prev <= irq_inputs;
      end
   end

   // Highest priority is bit 0; lower bits fence the ones above them
   always_comb begin
      is_low_mask = 8'hff;
      ack_sel     = 3'h0;
      ack_valid   = 1'b0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (in_service_register[i]) begin
            is_low_mask = 8'hff >> (NUM_IRQ - i);
         end
      end
      pending = request_register & ~mask_register & is_low_mask;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (pending[i]) begin
            ack_sel   = 3'(i);
            ack_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ack_d <= 1'b0;
      end else begin
         ack_d <= irq_ack_in;
      end
   end
   assign ack_rise = irq_ack_in && !ack_d;

   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         mask_register <= MASK_RESET;
      end else if (is_op) begin
         unique case (cmd[7:3])
            ICD_OP_CLR_ALL_M: mask_register <= ZERO8;
            ICD_OP_CLR_BIT_M: mask_register <= mask_register & ~bit_oh;
            ICD_OP_CLR_MASK:  mask_register <= ZERO8;
            ICD_OP_CLR_MBIT:  mask_register <= mask_register & ~bit_oh;
            ICD_OP_SET_MASK:  mask_register <= MASK_RESET;
            ICD_OP_SET_MBIT:  mask_register <= mask_register | bit_oh;
            default:          mask_register <= mask_register;
         endcase
      end else if (data_wr && target == ICD_TGT_MASK) begin
         mask_register <= pwdata[7:0];
      end
   end

   // Hardware edges win over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         request_register <= ZERO8;
      end else begin
         if (is_op) begin
            unique case (cmd[7:3])
               ICD_OP_CLR_ALL_M: request_register <= irq_edge;
               ICD_OP_CLR_BIT_M: request_register <= (req_base & ~bit_oh) | irq_edge;
               ICD_OP_CLR_REQ:   request_register <= irq_edge;
               ICD_OP_CLR_RBIT:  request_register <= (req_base & ~bit_oh) | irq_edge;
               ICD_OP_SET_REQ:   request_register <= MASK_RESET;
               ICD_OP_SET_RBIT:  request_register <= req_base | bit_oh | irq_edge;
               default:          request_register <= req_base | irq_edge;
            endcase
         end else begin
            // An acknowledge beside a command still takes its request
            request_register <= req_base | irq_edge;
         end
      end
   end

   // Clear half of the in-service update
   always_comb begin
      isr_cleared = in_service_register;
      if (op_excl) begin
         // Bit 0 ranks highest, so the lowest set bit is the one to go
         for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (in_service_register[i]) begin
               isr_cleared = in_service_register & ~(8'h01 << i);
            end
         end
      end else if (is_op && cmd[7:3] == ICD_OP_CLR_ISALL) begin
         isr_cleared = ZERO8;
      end else if (is_op && cmd[7:3] == ICD_OP_CLR_ISBIT) begin
         isr_cleared = in_service_register & ~bit_oh;
      end
   end

   // An acknowledge set beats a clear command in the same cycle
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         in_service_register <= ZERO8;
      end else begin
         in_service_register <= isr_cleared | isr_set;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         auto_clear_register <= ZERO8;
      end else if (data_wr && target == ICD_TGT_ACLR) begin
         auto_clear_register <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         mode <= ZERO8;
      end else if (op_mode) begin
         mode[4:0] <= cmd[4:0];
      end else if (op_ctl) begin
         mode[6:5] <= cmd[3:2];
         unique case (cmd[1:0])
            ARM_SET:  mode[MODE_ARM] <= 1'b1;
            ARM_CLR:  mode[MODE_ARM] <= 1'b0;
            default:  mode[MODE_ARM] <= mode[MODE_ARM];
         endcase
      end
   end

   // Any command other than a target select (1011, 1100, 111) drops the data-port target
   always_ff @(posedge clk) begin
      if (reset || soft_rst) begin
         target     <= ICD_TGT_NONE;
         resp_level <= 3'h0;
      end else if (cmd_wr) begin
         if (cmd[7:4] == 4'hb) begin
            target <= ICD_TGT_MASK;
         end else if (cmd[7:4] == 4'hc) begin
            target <= ICD_TGT_ACLR;
         end else if (op_resp) begin
            target     <= ICD_TGT_RESP;
            resp_level <= cmd[2:0];
         end else begin
            target <= ICD_TGT_NONE;
         end
      end
   end

   // Response sequence: one level owns acknowledges until its last byte
   always_ff @(posedge clk) begin
      if (reset) begin
         in_resp  <= 1'b0;
         resp_sel <= 3'h0;
      end else if (mem_ack) begin
         if (!in_resp) begin
            resp_sel <= ack_sel;
         end
         in_resp <= 1'b1;
      end else if (mem_last) begin
         // Last byte out: the next acknowledge starts a fresh selection
         in_resp <= 1'b0;
      end
   end

   logic [2:0] mem_level;
   assign mem_level = in_resp ? resp_sel : ack_sel;

   icd_resp_mem u_mem (
      .clk       (clk),
      .reset     (reset),
      .sel_level (op_resp),
      .level     (op_resp ? cmd[2:0] : resp_level),
      .count_in  (cmd[4:3]),
      .wr_byte   (data_wr && target == ICD_TGT_RESP),
      .wr_data   (pwdata[7:0]),
      .ack       (mem_ack),
      .ack_level (mem_level),
      .rd_data   (mem_byte),
      .rd_last   (mem_last)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         resp_byte <= ZERO8;
         resp_last <= 1'b0;
      end else begin
         resp_byte <= mem_byte;
         resp_last <= mem_last;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         group_irq_out <= 1'b0;
         enable_out    <= 1'b0;
      end else begin
         group_irq_out <= armed && |pending;
         enable_out    <= armed && !ack_valid;
      end
   end

   always_comb begin
      unique case (mode[6:5])
         RSEL_IRR: read_sel_value = request_register;
         RSEL_ISR: read_sel_value = in_service_register;
         RSEL_IMR: read_sel_value = mask_register;
         RSEL_ACR: read_sel_value = auto_clear_register;
      endcase
   end

   always_comb begin
      next_prdata = 32'h0;
      unique case (paddr)
         ADDR_DATA:   next_prdata[7:0] = read_sel_value;
         ADDR_STATUS: next_prdata[7:0] = {in_resp, ack_sel, 2'(target), group_irq_out, armed};
         ADDR_IRR:    next_prdata[7:0] = request_register;
         ADDR_ISR:    next_prdata[7:0] = in_service_register;
         ADDR_IMR:    next_prdata[7:0] = mask_register;
         ADDR_ACR:    next_prdata[7:0] = auto_clear_register;
         ADDR_MODE:   next_prdata[7:0] = mode;
         ADDR_RESP:   next_prdata[7:0] = resp_byte;
         default:     next_prdata = 32'h0;
      endcase
   end

   // Zero-wait slave: ready in the access cycle; addresses above ADDR_RESP error
   always_ff @(posedge clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && paddr > ADDR_RESP;
         prdata  <= next_prdata;
      end
   end
endmodule

// >>> verification/icd_monitor.sv
`timescale 1ns/1ps
module icd_monitor
   import icd_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq_ack_in,
   input wire logic        group_irq_out,
   input wire logic        enable_out
);
   import icd_pkg::*;
   logic       cmd_wr;
   logic [7:0] cmd;
   // Command counts only at the access edge that pready closes
   assign cmd_wr = psel && penable && pready && pwrite && (paddr == ADDR_CMD);
   assign cmd    = pwdata[7:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_unmapped: assert property (pready && paddr > ADDR_RESP |-> pslverr)
      else $error("no error on unmapped address");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error outside access");
   a_reset_quiet: assert property (cmd_wr && cmd == 8'h00 |-> ##2 !group_irq_out[*2])
      else $error("group active after reset command");
   a_clr_all_quiet: assert property (cmd_wr && cmd[7:3] == 5'b00010 |-> ##2 !group_irq_out)
      else $error("group active after clear all");
   a_mask_all_quiet: assert property (cmd_wr && cmd[7:3] == 5'b00110 |-> ##2 !group_irq_out)
      else $error("group active after mask all");
   a_req_clr_quiet: assert property (cmd_wr && cmd[7:3] == 5'b01000 |-> ##2 !group_irq_out)
      else $error("group active after request clear");
   a_disarm_quiet: assert property (cmd_wr && cmd[7:4] == 4'b1010 && cmd[1:0] == ARM_CLR
      |-> ##2 !group_irq_out)
      else $error("group active after disarm");
   a_enable_excl: assert property (group_irq_out |-> !enable_out)
      else $error("enable out high while group active");
   a_disarm_eo_low: assert property (cmd_wr && cmd[7:4] == 4'b1010 && cmd[1:0] == ARM_CLR
      |-> ##2 !enable_out)
      else $error("enable out high after disarm");
   c_reset_cmd: cover property (cmd_wr && cmd == 8'h00);
   c_group_rise: cover property ($rose(group_irq_out));
   c_slave_err: cover property (pslverr);
   c_ack_rise: cover property ($rose(irq_ack_in));
endmodule
bind icd_decoder icd_monitor u_monitor (.clk(clk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .irq_ack_in(irq_ack_in), .group_irq_out(group_irq_out),
   .enable_out(enable_out));

// >>> verification/icd_host.sv
`timescale 1ns/1ps
module icd_host (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // No cycle count assumed: the bench watchdog bounds a stuck slave
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show garbage, not the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import icd_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, group_irq_out, enable_out, resp_last;
   logic [7:0]  paddr, resp_byte;
   logic [31:0] pwdata, prdata;
   logic [7:0]  irq_inputs = 8'hff;
   logic        irq_ack_in = 1'b0;
   logic [15:0] rnd = 16'h0063;
   logic [7:0]  m_mask, m_req, m_isr, m_acr, m_mode, c;
   icd_tgt_t    tgt;
   int          n_fail = 0;
   int          check_count = 0;
   logic [31:0] q;
   logic        e;

   always #12.5 clk = ~clk;

   icd_decoder u_icd_decoder (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_inputs(irq_inputs), .irq_ack_in(irq_ack_in),
      .group_irq_out(group_irq_out), .enable_out(enable_out), .resp_byte(resp_byte),
      .resp_last(resp_last));
   icd_host u_icd_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic void predict(input logic [7:0] k);
      logic [7:0] b;
      b = 8'h01 << k[2:0];
      tgt = ICD_TGT_NONE;
      casez (k)
         8'b0000_0000: begin
            m_mask = MASK_RESET;
            {m_req, m_isr, m_acr, m_mode} = {4{ZERO8}};
         end
         8'b0001_0???: {m_mask, m_req} = {ZERO8, ZERO8};
         8'b0001_1???: {m_mask, m_req} = {m_mask & ~b, m_req & ~b};
         8'b0010_0???: m_mask = ZERO8;
         8'b0010_1???: m_mask = m_mask & ~b;
         8'b0011_0???: m_mask = MASK_RESET;
         8'b0011_1???: m_mask = m_mask | b;
         8'b0100_0???: m_req = ZERO8;
         8'b0100_1???: m_req = m_req & ~b;
         8'b0101_0???: m_req = 8'hff;
         8'b0101_1???: m_req = m_req | b;
         // Bit 0 is highest priority, so the lowest set bit goes
         8'b0110_????: m_isr = m_isr & (m_isr - 8'h01);
         8'b0111_0???: m_isr = ZERO8;
         8'b0111_1???: m_isr = m_isr & ~b;
         8'b100?_????: m_mode[4:0] = k[4:0];
         8'b1010_????: begin
            m_mode[6:5] = k[3:2];
            if (k[1:0] == ARM_SET) m_mode[MODE_ARM] = 1'b1;
            if (k[1:0] == ARM_CLR) m_mode[MODE_ARM] = 1'b0;
         end
         8'b1011_????: tgt = ICD_TGT_MASK;
         8'b1100_????: tgt = ICD_TGT_ACLR;
         8'b111?_????: tgt = ICD_TGT_RESP;
         default: ;
      endcase
   endfunction

   function automatic logic grp_exp();
      for (int i = 0; i < NUM_IRQ; i++) begin
         if (m_isr[i]) return 1'b0;
         if (m_req[i] && !m_mask[i]) return m_mode[MODE_ARM];
      end
      return 1'b0;
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      rnd = lfsr(rnd);
      u_icd_host.xfer(1'b1, a, {rnd[7:0], rnd, d}, q, e);
   endtask

   task automatic cmd(input logic [7:0] k);
      predict(k);
      wr(ADDR_CMD, k);
   endtask

   task automatic dat(input logic [7:0] d);
      if (tgt == ICD_TGT_MASK) m_mask = d;
      if (tgt == ICD_TGT_ACLR) m_acr = d;
      wr(ADDR_DATA, d);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      u_icd_host.xfer(1'b0, a, 32'h0, q, e);
      chk(name, {24'h0, exp}, q);
   endtask

   task automatic check_regs;
      logic [7:0] sel;
      sel = (m_mode[6:5] == RSEL_IRR) ? m_req : (m_mode[6:5] == RSEL_ISR) ? m_isr :
            (m_mode[6:5] == RSEL_IMR) ? m_mask : m_acr;
      rd_chk("request", ADDR_IRR, m_req);
      rd_chk("mask", ADDR_IMR, m_mask);
      rd_chk("auto clear", ADDR_ACR, m_acr);
      rd_chk("mode", ADDR_MODE, m_mode);
      rd_chk("in service", ADDR_ISR, m_isr);
      rd_chk("data port", ADDR_DATA, sel);
      u_icd_host.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk("status", {28'h0, tgt, grp_exp(), m_mode[MODE_ARM]}, {28'h0, q[3:0]});
      chk("enable out", {31'h0, m_mode[MODE_ARM] && !grp_exp()}, {31'h0, enable_out});
   endtask

   task automatic ack(input logic [7:0] b, input logic last);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      irq_ack_in <= 1'b1;
      repeat (3) @(posedge clk);
      repeat (3) begin
         @(posedge clk);
         seen = seen | (resp_last === 1'b1);
      end
      irq_ack_in <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk("response byte", ADDR_RESP, b);
      chk("response port", {24'h0, b}, {24'h0, resp_byte});
      chk("last flag", {31'h0, last}, {31'h0, seen});
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      cmd(8'h00);
      for (int k = 0; k < 80; k++) begin
         rnd = lfsr(rnd);
         c = rnd[7:0];
         if (c[7:3] == 5'h00) c = 8'h00;
         // Edge polarity and polled bits stay put: inputs are idle high
         if (c[7:5] == 3'b100) c = c & 8'heb;
         cmd(c);
         if (rnd[8]) dat(rnd[15:8]);
         if (rnd[9]) dat(rnd[14:7]);
         check_regs();
      end
      u_icd_host.xfer(1'b0, 8'h24, 32'h0, q, e);
      chk("slave error", 32'h1, {31'h0, e});
      wr(ADDR_IRR, 8'h55);
      check_regs();
      cmd(8'h00);
      cmd(8'he9);
      dat(8'ha1);
      dat(8'hb2);
      cmd(8'he3);
      dat(8'hc3);
      cmd(8'h00);
      cmd(8'h5b);
      cmd(8'h20);
      cmd(8'ha1);
      check_regs();
      ack(8'hc3, 1'b1);
      m_req[3] = 1'b0;
      m_isr[3] = 1'b1;
      cmd(8'h59);
      ack(8'ha1, 1'b0);
      m_req[1] = 1'b0;
      m_isr[1] = 1'b1;
      ack(8'hb2, 1'b1);
      check_regs();
      cmd(8'h60);
      check_regs();
      cmd(8'h7b);
      check_regs();
      cmd(8'h7b);
      check_regs();
      irq_inputs <= 8'hbf;
      repeat (4) @(posedge clk);
      m_req[6] = 1'b1;
      check_regs();
      cmd(8'h40);
      check_regs();
      // Rising sense: the pin returning high is now a fresh request
      cmd(8'h90);
      irq_inputs <= 8'hff;
      repeat (4) @(posedge clk);
      m_req[6] = 1'b1;
      check_regs();
      summarize();
   end
endmodule
